// file: rtl/acc_pkg.sv
/*
 * acc_pkg: register map, field layout, channel codes and state encoding
 * for the converter channel and clock control block.
 * Assumes an 8-bit register port and a single 100 MHz system clock.
 */
package acc_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int RES_W = 8;

    // register offsets
    localparam logic [7:0] STATUS_OFF = 8'h3C;
    localparam logic [7:0] RESULT_OFF = 8'h3D;
    localparam logic [7:0] CLOCK_OFF = 8'h3E;

    // reset values
    localparam logic [7:0] STATUS_RST = 8'h1F;
    localparam logic [7:0] RESULT_RST = 8'h00;
    localparam logic [7:0] CLOCK_RST = 8'h00;

    // status/control fields
    localparam int DONE_BIT = 7;
    localparam int CONT_BIT = 5;
    localparam int CHAN_LSB = 0;
    localparam int CHAN_W = 5;

    // clock control fields
    localparam int DIV_LSB = 5;
    localparam int DIV_W = 3;
    localparam int ICLK_BIT = 4;

    // channel codes
    localparam logic [4:0] CHAN_REFH = 5'h1D;
    localparam logic [4:0] CHAN_REFL = 5'h1E;
    localparam logic [4:0] CHAN_OFF = 5'h1F;
    localparam logic [4:0] PIN_LIMIT = 5'h08;
    localparam int PIN_COUNT = 8;

    // clock source select values
    localparam logic ICLK_BUS = 1'b1;
    localparam logic ICLK_OSC = 1'b0;

    // divider terminal counts
    localparam int DIVCNT_W = 4;
    localparam logic [3:0] LAST_DIV1 = 4'h0;
    localparam logic [3:0] LAST_DIV2 = 4'h1;
    localparam logic [3:0] LAST_DIV4 = 4'h3;
    localparam logic [3:0] LAST_DIV8 = 4'h7;
    localparam logic [3:0] LAST_DIV16 = 4'hF;

    // approximation start
    localparam logic [7:0] TRIAL_MSB = 8'h80;
    localparam logic [2:0] BIT_TOP = 3'h7;
    localparam logic [2:0] BIT_LAST = 3'h0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b10
    } acc_state_type;

endpackage : acc_pkg

// file: rtl/acc_clk_div.sv
/*
 * acc_clk_div: divides a stream of input clock ticks by a power of two.
 * Assumes tick_i is a one-cycle enable on clk_i from the selected source.
 */
`timescale 1ns/1ps

module acc_clk_div (
    input wire logic clk_i, // system clock
    input wire logic nrst_i, // sync reset, active low
    input wire logic tick_i, // selected source tick
    input wire logic [2:0] ratio_i, // divider field
    output logic tick_o // converter clock tick
);

    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic tick_reg;
    logic tick_next;

    function automatic logic [3:0] last_count(input logic [2:0] code);
        case (code)
            3'h0: last_count = acc_pkg::LAST_DIV1;
            3'h1: last_count = acc_pkg::LAST_DIV2;
            3'h2: last_count = acc_pkg::LAST_DIV4;
            3'h3: last_count = acc_pkg::LAST_DIV8;
            default: last_count = acc_pkg::LAST_DIV16;
        endcase
    endfunction : last_count

    always_comb begin
        cnt_next = cnt_reg;
        tick_next = 1'b0;
        if (tick_i) begin
            if (cnt_reg >= last_count(ratio_i)) begin
                cnt_next = 4'h0;
                tick_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            cnt_reg <= 4'h0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick_o = tick_reg;

    a_div_by_one: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (tick_i && ratio_i == 3'h0) |=> tick_o)
        else $error("divide by one lost a tick");

    a_div_by_two: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (tick_o && $past(ratio_i) == 3'h1 && ratio_i == 3'h1) |-> !$past(tick_o))
        else $error("divide by two ticked twice in a row");

endmodule : acc_clk_div

// file: rtl/acc_ctrl.sv
/*
 * acc_ctrl: channel select, conversion sequencing, result register and
 * converter clock control of an 8-bit successive approximation converter.
 * Assumes the analog core outside offers a comparator (cmp_i, same clock)
 * that is high while the sampled input is at or above dac_code_o, and that
 * the external oscillator arrives as an asynchronous pin.
 */
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps

// Function
// - continuous bit repeats conversions back to back
// - each conversion end except a settling one or one in the same cycle as a status write loads the result register
// - single mode: one conversion per write
// - reset clears the continuous bit
// - five-bit channel, codes 0-7 select pins
// - codes 1D/1E route high/low reference
// - all-ones channel powers converter off
// - first conversion after power-on only settles
// - reserved channels give undefined results
// - clock select 1 bus, 0 oscillator
// - selected clock divided toward about 1 MHz
module acc_ctrl (
    input wire logic clk_i, // system bus clock
    input wire logic nrst_i, // sync reset, active low
    input wire logic [7:0] addr_i, // register address
    input wire logic [7:0] wdata_i, // write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    output logic [7:0] rdata_o, // read data, cycle after rd_i
    input wire logic osc_clk_i, // external oscillator pin
    input wire logic cmp_i, // comparator from analog core
    output logic [7:0] dac_code_o, // trial code to analog core
    output logic sample_o, // sample phase to analog core
    output logic power_off_o, // converter power down
    output logic [7:0] pin_sel_o, // one-hot analog pin select
    output logic ref_high_o, // high reference routed
    output logic ref_low_o // low reference routed
);

    // register state
    logic cont_reg;
    logic cont_next;
    logic [4:0] chan_reg;
    logic [4:0] chan_next;
    logic done_reg;
    logic done_next;
    logic [7:0] result_reg;
    logic [7:0] result_next;
    logic [2:0] div_reg;
    logic [2:0] div_next;
    logic iclk_reg;
    logic iclk_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    // oscillator synchroniser state
    logic osc_s1_reg;
    logic osc_s2_reg;
    logic osc_s3_reg;
    logic osc_lvl_reg;
    logic osc_lvl_next;
    logic osc_rise;

    // sequencer state
    acc_pkg::acc_state_type state_reg;
    acc_pkg::acc_state_type state_next;
    logic [7:0] trial_reg;
    logic [7:0] trial_next;
    logic [2:0] bit_reg;
    logic [2:0] bit_next;
    logic pend_reg;
    logic pend_next;
    logic settle_reg;
    logic settle_next;

    // analog side outputs
    logic sample_reg;
    logic sample_next;
    logic off_reg;
    logic off_next;
    logic [7:0] pin_reg;
    logic [7:0] pin_next;
    logic refh_reg;
    logic refh_next;
    logic refl_reg;
    logic refl_next;

    // decode strobes
    logic wr_status;
    logic wr_clock;
    logic src_tick;
    logic ctick;
    logic chan_is_off;
    logic last_step;
    logic load;
    logic [7:0] final_code;

    function automatic logic [7:0] read_mux(
        input logic [7:0] addr,
        input logic done,
        input logic cont,
        input logic [4:0] chan,
        input logic [7:0] result,
        input logic [2:0] div,
        input logic iclk
    );
        logic [7:0] value;
        value = 8'h00;
        case (addr)
            acc_pkg::STATUS_OFF: begin
                value[acc_pkg::DONE_BIT] = done;
                value[acc_pkg::CONT_BIT] = cont;
                value[acc_pkg::CHAN_LSB +: acc_pkg::CHAN_W] = chan;
            end
            acc_pkg::RESULT_OFF: value = result;
            acc_pkg::CLOCK_OFF: begin
                value[acc_pkg::DIV_LSB +: acc_pkg::DIV_W] = div;
                value[acc_pkg::ICLK_BIT] = iclk;
            end
            default: value = 8'h00;
        endcase
        read_mux = value;
    endfunction : read_mux

    assign wr_status = wr_i && (addr_i == acc_pkg::STATUS_OFF);
    assign wr_clock = wr_i && (addr_i == acc_pkg::CLOCK_OFF);

    // register file
    always_comb begin
        cont_next = cont_reg;
        chan_next = chan_reg;
        div_next = div_reg;
        iclk_next = iclk_reg;
        if (wr_status) begin
            cont_next = wdata_i[acc_pkg::CONT_BIT];
            chan_next = wdata_i[acc_pkg::CHAN_LSB +: acc_pkg::CHAN_W];
        end
        if (wr_clock) begin
            div_next = wdata_i[acc_pkg::DIV_LSB +: acc_pkg::DIV_W];
            iclk_next = wdata_i[acc_pkg::ICLK_BIT];
        end
        rdata_next = 8'h00;
        if (rd_i) begin
            rdata_next = read_mux(addr_i, done_reg, cont_reg, chan_reg, result_reg, div_reg, iclk_reg);
        end
        done_next = done_reg;
        if (wr_status) begin
            done_next = 1'b0;
        end
        if (load) begin
            done_next = 1'b1;
        end
        result_next = load ? final_code : result_reg;
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            cont_reg <= acc_pkg::STATUS_RST[acc_pkg::CONT_BIT];
            chan_reg <= acc_pkg::STATUS_RST[acc_pkg::CHAN_LSB +: acc_pkg::CHAN_W];
            done_reg <= acc_pkg::STATUS_RST[acc_pkg::DONE_BIT];
            result_reg <= acc_pkg::RESULT_RST;
            div_reg <= acc_pkg::CLOCK_RST[acc_pkg::DIV_LSB +: acc_pkg::DIV_W];
            iclk_reg <= acc_pkg::CLOCK_RST[acc_pkg::ICLK_BIT];
            rdata_reg <= 8'h00;
        end else begin
            cont_reg <= cont_next;
            chan_reg <= chan_next;
            done_reg <= done_next;
            result_reg <= result_next;
            div_reg <= div_next;
            iclk_reg <= iclk_next;
            rdata_reg <= rdata_next;
        end
    end

    // oscillator edge, counted once second and third stages agree
    always_comb begin
        osc_lvl_next = osc_lvl_reg;
        osc_rise = 1'b0;
        if (osc_s2_reg == osc_s3_reg) begin
            osc_lvl_next = osc_s3_reg;
            osc_rise = osc_s3_reg && !osc_lvl_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            osc_s1_reg <= 1'b0;
            osc_s2_reg <= 1'b0;
            osc_s3_reg <= 1'b0;
            osc_lvl_reg <= 1'b0;
        end else begin
            osc_s1_reg <= osc_clk_i;
            osc_s2_reg <= osc_s1_reg;
            osc_s3_reg <= osc_s2_reg;
            osc_lvl_reg <= osc_lvl_next;
        end
    end

    assign src_tick = (iclk_reg == acc_pkg::ICLK_BUS) ? 1'b1 : osc_rise;

    acc_clk_div u_div (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .tick_i(src_tick),
        .ratio_i(div_reg),
        .tick_o(ctick)
    );

    assign chan_is_off = (chan_reg == acc_pkg::CHAN_OFF);
    assign last_step = ctick && (state_reg == acc_pkg::ST_CONVERT) && (bit_reg == acc_pkg::BIT_LAST);
    assign final_code = cmp_i ? trial_reg : (trial_reg & ~(8'h01 << bit_reg));
    assign load = last_step && !settle_reg && !wr_status;

    // conversion sequencer
    always_comb begin
        state_next = state_reg;
        trial_next = trial_reg;
        bit_next = bit_reg;
        pend_next = pend_reg;
        settle_next = settle_reg;
        sample_next = 1'b0;
        case (state_reg)
            acc_pkg::ST_IDLE: begin
                if (ctick && pend_reg) begin
                    pend_next = 1'b0;
                    state_next = acc_pkg::ST_SAMPLE;
                    sample_next = 1'b1;
                end
            end
            acc_pkg::ST_SAMPLE: begin
                sample_next = !ctick;
                if (ctick) begin
                    trial_next = acc_pkg::TRIAL_MSB;
                    bit_next = acc_pkg::BIT_TOP;
                    state_next = acc_pkg::ST_CONVERT;
                end
            end
            acc_pkg::ST_CONVERT: begin
                if (ctick) begin
                    if (bit_reg == acc_pkg::BIT_LAST) begin
                        trial_next = final_code;
                        if (settle_reg) begin
                            settle_next = 1'b0;
                            state_next = acc_pkg::ST_SAMPLE;
                            sample_next = 1'b1;
                        end else if (cont_reg) begin
                            state_next = acc_pkg::ST_SAMPLE;
                            sample_next = 1'b1;
                        end else begin
                            state_next = acc_pkg::ST_IDLE;
                        end
                    end else begin
                        trial_next = final_code | (8'h01 << (bit_reg - 3'h1));
                        bit_next = bit_reg - 3'h1;
                    end
                end
            end
            default: state_next = acc_pkg::ST_IDLE;
        endcase
        // each status write with a channel other than all-ones starts a fresh conversion
        if (wr_status) begin
            state_next = acc_pkg::ST_IDLE;
            sample_next = 1'b0;
            pend_next = (wdata_i[acc_pkg::CHAN_LSB +: acc_pkg::CHAN_W] != acc_pkg::CHAN_OFF);
        end
        if (chan_is_off) begin
            state_next = acc_pkg::ST_IDLE;
            sample_next = 1'b0;
            pend_next = wr_status && pend_next;
            settle_next = 1'b1;
        end
    end

    // analog side decode
    always_comb begin
        off_next = chan_is_off;
        pin_next = 8'h00;
        if (chan_reg < acc_pkg::PIN_LIMIT) begin
            pin_next = 8'h01 << chan_reg[2:0];
        end
        // reference routing; reserved codes select nothing
        refh_next = (chan_reg == acc_pkg::CHAN_REFH);
        refl_next = (chan_reg == acc_pkg::CHAN_REFL);
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            state_reg <= acc_pkg::ST_IDLE;
            trial_reg <= 8'h00;
            bit_reg <= acc_pkg::BIT_TOP;
            pend_reg <= 1'b0;
            settle_reg <= 1'b1;
            sample_reg <= 1'b0;
            off_reg <= 1'b1;
            pin_reg <= 8'h00;
            refh_reg <= 1'b0;
            refl_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            trial_reg <= trial_next;
            bit_reg <= bit_next;
            pend_reg <= pend_next;
            settle_reg <= settle_next;
            sample_reg <= sample_next;
            off_reg <= off_next;
            pin_reg <= pin_next;
            refh_reg <= refh_next;
            refl_reg <= refl_next;
        end
    end

    assign rdata_o = rdata_reg;
    assign dac_code_o = trial_reg;
    assign sample_o = sample_reg;
    assign power_off_o = off_reg;
    assign pin_sel_o = pin_reg;
    assign ref_high_o = refh_reg;
    assign ref_low_o = refl_reg;

    a_result_on_load: assert property (@(posedge clk_i) disable iff (!nrst_i)
        load |=> (result_reg == $past(final_code)) && done_reg)
        else $error("result not loaded at conversion end");
    a_cont_repeats: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (last_step && cont_reg && !chan_is_off && !wr_status) |=> (state_reg == acc_pkg::ST_SAMPLE) && sample_o)
        else $error("continuous mode did not restart");
    a_single_stops: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (last_step && !cont_reg && !settle_reg && !wr_status && !chan_is_off) |=> (state_reg == acc_pkg::ST_IDLE)
        ##1 (state_reg == acc_pkg::ST_IDLE || $past(wr_status)))
        else $error("single mode kept converting");
    a_reset_single: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $rose(nrst_i) |-> !cont_reg && !iclk_reg && chan_is_off)
        else $error("reset values wrong");
    a_pin_decode: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (chan_reg < acc_pkg::PIN_LIMIT) |=> pin_sel_o == (8'h01 << $past(chan_reg[2:0])))
        else $error("pin select mismatch");
    a_ref_route: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (chan_reg == acc_pkg::CHAN_REFH) |=> ref_high_o && !ref_low_o && (pin_sel_o == 8'h00))
        else $error("high reference not routed");
    a_off_idle: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (chan_is_off [*2]) |=> !sample_o && power_off_o && (state_reg == acc_pkg::ST_IDLE))
        else $error("converter active while powered off");
    a_settle_discard: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (last_step && settle_reg) |=> $stable(result_reg) && (state_reg == acc_pkg::ST_SAMPLE || $past(wr_status)))
        else $error("settling result was loaded");
    a_done_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (wr_status && !load) |=> !done_reg)
        else $error("done flag not cleared by write");
    a_read_latency: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (rd_i && addr_i == acc_pkg::CLOCK_OFF) |=> rdata_o[acc_pkg::ICLK_BIT] == $past(iclk_reg))
        else $error("clock select readback wrong");

endmodule : acc_ctrl

// file: verif/acc_ctrl_tb_top.sv
/*
 * acc_ctrl_tb_top: self-checking bench for the converter channel and clock control.
 * Assumes the acc_ctrl ports as declared; comparator held constant per scenario.
 */
`timescale 1ns/1ps

module acc_ctrl_tb_top;
    logic clk_i, nrst_i, wr_i, rd_i, osc_clk_i, cmp_i;
    logic [7:0] addr_i, wdata_i, rdata_o, dac_code_o, pin_sel_o;
    logic sample_o, power_off_o, ref_high_o, ref_low_o;
    logic samp_q, osc_run;
    int samp_cnt, hi_len, last_hi, osc_div, error_cnt, n_checks;

    acc_ctrl dut_u (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .osc_clk_i(osc_clk_i),
        .cmp_i(cmp_i),
        .dac_code_o(dac_code_o),
        .sample_o(sample_o),
        .power_off_o(power_off_o),
        .pin_sel_o(pin_sel_o),
        .ref_high_o(ref_high_o),
        .ref_low_o(ref_low_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // counts sample pulses and their length
    always @(posedge clk_i) begin
        samp_q <= sample_o;
        if (sample_o) hi_len <= hi_len + 1;
        if (sample_o && !samp_q) samp_cnt <= samp_cnt + 1;
        if (!sample_o && samp_q) begin
            last_hi <= hi_len;
            hi_len <= 0;
        end
    end

    // oscillator above 1 MHz
    // oscillator pin, period of 8 system cycles while running
    always @(posedge clk_i) begin
        if (osc_run) begin
            osc_div <= osc_div + 1;
            if (osc_div == 3) begin
                osc_div <= 0;
                osc_clk_i <= ~osc_clk_i;
            end
        end
    end

    task automatic give_verdict();
        if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask : reg_read

    task automatic wait_done(output logic [7:0] st);
        int i;
        st = 8'h00;
        for (i = 0; i < 400 && st[7] !== 1'b1; i++) reg_read(8'h3C, st);
        chk("done flag", 8'h01, {7'h00, st[7]});
    endtask : wait_done

    task automatic t_reset_map();
        logic [7:0] d;
        reg_read(8'h3C, d);
        chk("status reset", 8'h1F, d);
        reg_read(8'h3D, d);
        chk("result reset", 8'h00, d);
        reg_read(8'h3E, d);
        chk("clock reset", 8'h00, d);
        chk("power off at reset", 8'h01, {7'h00, power_off_o});
        reg_write(8'h3F, 8'hAA);
        reg_read(8'h3F, d);
        chk("unmapped read", 8'h00, d);
        reg_write(8'h3D, 8'h55);
        reg_read(8'h3D, d);
        chk("result read only", 8'h00, d);
        reg_write(8'h3E, 8'hFF);
        reg_read(8'h3E, d);
        chk("clock readback", 8'hF0, d);
        reg_write(8'h3C, 8'hDF);
        reg_read(8'h3C, d);
        chk("status readback", 8'h1F, d);
    endtask : t_reset_map

    task automatic t_routing();
        logic [4:0] codes [12] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
            5'h08, 5'h1C, 5'h1D, 5'h1E};
        logic [7:0] exp_pin;
        reg_write(8'h3E, 8'h10);
        foreach (codes[i]) begin
            exp_pin = (codes[i] < 5'h08) ? (8'h01 << codes[i]) : 8'h00;
            reg_write(8'h3C, {3'h0, codes[i]});
            repeat (2) @(posedge clk_i);
            #1;
            chk("pin select", exp_pin, pin_sel_o);
            chk("high ref", {7'h00, codes[i] == 5'h1D}, {7'h00, ref_high_o});
            chk("low ref", {7'h00, codes[i] == 5'h1E}, {7'h00, ref_low_o});
            chk("powered", 8'h00, {7'h00, power_off_o});
        end
        reg_write(8'h3C, 8'h1F);
        repeat (2) @(posedge clk_i);
        #1;
        chk("power off", 8'h01, {7'h00, power_off_o});
        chk("off pin select", 8'h00, pin_sel_o);
    endtask : t_routing

    task automatic t_settle_single();
        logic [7:0] st, d;
        int base;
        @(posedge clk_i);
        cmp_i <= 1'b1;
        base = samp_cnt;
        reg_write(8'h3C, 8'h00);
        wait_done(st);
        chk("status after settle", 8'h80, st);
        chk("settle samples", 8'h02, 8'(samp_cnt - base));
        chk("trial code all ones", 8'hFF, dac_code_o);
        reg_read(8'h3D, d);
        chk("result all ones", 8'hFF, d);
        @(posedge clk_i);
        cmp_i <= 1'b0;
        base = samp_cnt;
        reg_write(8'h3C, 8'h00);
        reg_read(8'h3C, d);
        chk("done cleared by write", 8'h00, d);
        wait_done(st);
        chk("single samples", 8'h01, 8'(samp_cnt - base));
        chk("trial code all zeros", 8'h00, dac_code_o);
        reg_read(8'h3D, d);
        chk("result all zeros", 8'h00, d);
        repeat (60) @(posedge clk_i);
        chk("no further samples", 8'h01, 8'(samp_cnt - base));
    endtask : t_settle_single

    task automatic t_divider();
        logic [2:0] divs [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
        logic [7:0] ratio [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h10};
        logic [7:0] st;
        foreach (divs[i]) begin
            reg_write(8'h3E, {divs[i], 1'b1, 4'h0});
            reg_write(8'h3C, 8'h00);
            wait_done(st);
            chk("sample length", ratio[i], 8'(last_hi));
        end
    endtask : t_divider

    task automatic t_clock_source();
        logic [7:0] st, d;
        reg_write(8'h3E, 8'h00);
        reg_write(8'h3C, 8'h00);
        repeat (100) @(posedge clk_i);
        reg_read(8'h3C, d);
        chk("done with oscillator stopped", 8'h00, d);
        @(posedge clk_i);
        osc_run <= 1'b1;
        wait_done(st);
        chk("done on oscillator", 8'h80, st);
        @(posedge clk_i);
        osc_run <= 1'b0;
    endtask : t_clock_source

    task automatic t_continuous();
        logic [7:0] st, d;
        int base;
        reg_write(8'h3E, 8'h10);
        @(posedge clk_i);
        cmp_i <= 1'b1;
        reg_write(8'h3C, 8'h20);
        wait_done(st);
        chk("continuous status", 8'hA0, st);
        reg_read(8'h3D, d);
        chk("continuous result", 8'hFF, d);
        @(posedge clk_i);
        cmp_i <= 1'b0;
        base = samp_cnt;
        repeat (60) @(posedge clk_i);
        reg_read(8'h3D, d);
        chk("updated without write", 8'h00, d);
        chk("repeated samples", 8'h01, {7'h00, (samp_cnt - base) >= 2});
        reg_write(8'h3C, 8'h3F);
        repeat (3) @(posedge clk_i);
        base = samp_cnt;
        repeat (60) @(posedge clk_i);
        chk("samples while off", 8'h00, 8'(samp_cnt - base));
        chk("off in continuous", 8'h01, {7'h00, power_off_o});
    endtask : t_continuous

    // reset in mid-run while continuous and bus clock are set
    task automatic t_reset_again();
        logic [7:0] d;
        int base;
        reg_write(8'h3C, 8'h20);
        repeat (5) @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        base = samp_cnt;
        reg_read(8'h3C, d);
        chk("status after reset", 8'h1F, d);
        reg_read(8'h3E, d);
        chk("clock after reset", 8'h00, d);
        repeat (40) @(posedge clk_i);
        chk("samples after reset", 8'h00, 8'(samp_cnt - base));
        chk("power off after reset", 8'h01, {7'h00, power_off_o});
    endtask : t_reset_again

    initial begin
        repeat (50000) @(posedge clk_i);
        error_cnt++;
        give_verdict();
    end

    initial begin
        nrst_i = 1'b0;
        addr_i = 8'h00;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        osc_clk_i = 1'b0;
        cmp_i = 1'b0;
        osc_run = 1'b0;
        samp_q = 1'b0;
        samp_cnt = 0;
        hi_len = 0;
        last_hi = 0;
        osc_div = 0;
        error_cnt = 0;
        n_checks = 0;
        repeat (20) @(posedge clk_i);
        nrst_i <= 1'b1;
        t_reset_map();
        t_routing();
        t_settle_single();
        t_divider();
        t_clock_source();
        t_continuous();
        t_reset_again();
        give_verdict();
    end
endmodule : acc_ctrl_tb_top
